// *** common/vdtc_pkg.sv ***
// Functional notes
// R1 - Divide value is 12 bits, upper byte plus low nibble; ratio is value plus one.
// R2 - Active divide value reloads only when the low-part register is written.
// R3 - Host programs divide values only between 2 and 4095.
// R4 - Divide value resets to 1693, upper 69h, low nibble dh.
// R5 - Band field bits 7:6 picks one of four pixel ranges and post-divider.
// R6 - Band field resets to 01.
// R7 - Pump current field bits 5:3 selects loop drive 50 to 1500 microamps.
// R8 - Pump current field resets to 001.
// R9 - Phase field bits 7:3 shifts sampling in 32 steps of 11.25 degrees.
// R10 - Phase field resets to step 16.
// R11 - Internal clamp starts placement pixel periods after line-sync trailing edge.
// R12 - Host programs clamp placement between 1 and 255.
// R13 - Clamp length register sets how long the internal clamp stays active.
// R14 - External clamp source ignores placement and length registers.
// R15 - Output line sync starts on feedback clock, ends after width pixel clocks.
// R16 - Register zero is a read-only silicon revision.
// R17 - Green and blue offset targets are eight bits resetting to 04h.
// R18 - Host writes the reserved register after the targets with 11h.
// R19 - Auto-offset bit 7 enables, bit 6 holds; both reset to zero.
// R20 - Host writes auto-offset control bits 5:2 with 9.
// R21 - Auto-offset bits 1:0 choose update rate, resetting to 10.
// R22 - Host leaves the factory test register at its default.
//
// Purpose: Constants and types for the video digitizer timing control bank.
// Assumes: Byte-wide register port at printed offsets.
// Notes: Revision value is arbitrary.
package vdtc_pkg;
    localparam logic [7:0] ADDR_REVISION = 8'h00;
    localparam logic [7:0] ADDR_DIV_UPPER = 8'h01;
    localparam logic [7:0] ADDR_DIV_LOWER = 8'h02;
    localparam logic [7:0] ADDR_CLKGEN = 8'h03;
    localparam logic [7:0] ADDR_PHASE = 8'h04;
    localparam logic [7:0] ADDR_CLAMP_START = 8'h05;
    localparam logic [7:0] ADDR_CLAMP_LEN = 8'h06;
    localparam logic [7:0] ADDR_SYNC_WIDTH = 8'h07;
    localparam logic [7:0] ADDR_GREEN_TGT = 8'h1a;
    localparam logic [7:0] ADDR_BLUE_TGT = 8'h1b;
    localparam logic [7:0] ADDR_RSV_FIXED = 8'h1c;
    localparam logic [7:0] ADDR_AO_CTRL = 8'h1d;
    localparam logic [7:0] ADDR_TEST = 8'h1e;
    localparam logic [7:0] SILICON_REVISION = 8'h01;
    localparam logic [7:0] RST_DIV_UPPER = 8'h69;
    localparam logic [7:0] RST_DIV_LOWER = 8'hd0;
    localparam logic [11:0] RST_DIVIDE = 12'h69d;
    localparam logic [7:0] RST_CLKGEN = 8'h48;
    localparam logic [7:0] RST_PHASE = 8'h80;
    localparam logic [7:0] RST_CLAMP_START = 8'h01;
    localparam logic [7:0] RST_CLAMP_LEN = 8'h01;
    localparam logic [7:0] RST_SYNC_WIDTH = 8'h01;
    localparam logic [7:0] RST_TARGET = 8'h04;
    localparam logic [7:0] RST_RSV_FIXED = 8'h11;
    localparam logic [7:0] RST_AO_CTRL = 8'h26;
    localparam logic [7:0] RST_TEST = 8'h00;
    localparam int BAND_HI = 7;
    localparam int BAND_LO = 6;
    localparam int PUMP_HI = 5;
    localparam int PUMP_LO = 3;
    localparam int PHASE_HI = 7;
    localparam int PHASE_LO = 3;
    localparam int AO_EN_BIT = 7;
    localparam int AO_HOLD_BIT = 6;
    localparam int AO_RATE_HI = 1;
    localparam int AO_RATE_LO = 0;
    localparam int DIV_NIB_HI = 7;
    localparam int DIV_NIB_LO = 4;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic [1:0] band;
        logic [2:0] pump;
        logic [4:0] phase;
        logic [11:0] divide;
        logic ao_enable;
        logic ao_hold;
        logic [1:0] ao_rate;
    } clock_cfg_type;
endpackage

// *** logic/video_digitizer_timing_control.sv ***
// Purpose: Register bank with internal clamp and output line-sync timing.
// Assumes: Runs on the recovered pixel clock; pins are synchronised here.
// Notes: Register writes come from the serial control port decoder.
`timescale 1ns/1ps
module video_digitizer_timing_control
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire vdtc_pkg::reg_req_type req,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic line_sync_in,
    input wire logic feedback_edge,
    input wire logic clamp_external,
    input wire logic clamp_pin,
    output vdtc_pkg::clock_cfg_type clock_cfg,
    output logic clamp_out,
    output logic line_sync_out,
    output logic [7:0] green_target,
    output logic [7:0] blue_target
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] div_upper;
        logic [7:0] div_lower;
        logic [11:0] divide;
        logic [7:0] clkgen;
        logic [7:0] phase;
        logic [7:0] clamp_start;
        logic [7:0] clamp_len;
        logic [7:0] sync_width;
        logic [7:0] green_tgt;
        logic [7:0] blue_tgt;
        logic [7:0] rsv_fixed;
        logic [7:0] ao_ctrl;
        logic [7:0] test;
        logic [2:0] sync_pipe;
        logic [2:0] clamp_pipe;
        logic sync_level;
        logic clamp_level;
        logic delay_run;
        logic [7:0] delay_cnt;
        logic clamp_run;
        logic [7:0] clamp_cnt;
        logic clamp_q;
        logic hs_run;
        logic [7:0] hs_cnt;
        logic [7:0] rd_q;
    } state_type;

    state_type s;
    state_type next_s;
    logic sync_fall;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        sync_fall = 1'b0;
        if (req.wr)
        begin
            unique case (req.addr)
                vdtc_pkg::ADDR_DIV_UPPER: next_s.div_upper = req.wdata;
                vdtc_pkg::ADDR_DIV_LOWER:
                begin
                    next_s.div_lower = req.wdata;
                    // Only the low-part write moves the active ratio.
                    next_s.divide = {s.div_upper,
                        req.wdata[vdtc_pkg::DIV_NIB_HI:vdtc_pkg::DIV_NIB_LO]}; // [R1] [R2]
                end
                vdtc_pkg::ADDR_CLKGEN: next_s.clkgen = req.wdata; // [R5] [R7]
                vdtc_pkg::ADDR_PHASE: next_s.phase = req.wdata; // [R9]
                vdtc_pkg::ADDR_CLAMP_START: next_s.clamp_start = req.wdata;
                vdtc_pkg::ADDR_CLAMP_LEN: next_s.clamp_len = req.wdata;
                vdtc_pkg::ADDR_SYNC_WIDTH: next_s.sync_width = req.wdata;
                vdtc_pkg::ADDR_GREEN_TGT: next_s.green_tgt = req.wdata; // [R17]
                vdtc_pkg::ADDR_BLUE_TGT: next_s.blue_tgt = req.wdata; // [R17]
                vdtc_pkg::ADDR_RSV_FIXED: next_s.rsv_fixed = req.wdata;
                vdtc_pkg::ADDR_AO_CTRL: next_s.ao_ctrl = req.wdata; // [R19] [R21]
                vdtc_pkg::ADDR_TEST: next_s.test = req.wdata;
                default: next_s.test = s.test;
            endcase
        end

        unique case (rd_addr)
            vdtc_pkg::ADDR_REVISION: next_s.rd_q = vdtc_pkg::SILICON_REVISION; // [R16]
            vdtc_pkg::ADDR_DIV_UPPER: next_s.rd_q = s.div_upper;
            vdtc_pkg::ADDR_DIV_LOWER: next_s.rd_q = s.div_lower;
            vdtc_pkg::ADDR_CLKGEN: next_s.rd_q = s.clkgen;
            vdtc_pkg::ADDR_PHASE: next_s.rd_q = s.phase;
            vdtc_pkg::ADDR_CLAMP_START: next_s.rd_q = s.clamp_start;
            vdtc_pkg::ADDR_CLAMP_LEN: next_s.rd_q = s.clamp_len;
            vdtc_pkg::ADDR_SYNC_WIDTH: next_s.rd_q = s.sync_width;
            vdtc_pkg::ADDR_GREEN_TGT: next_s.rd_q = s.green_tgt;
            vdtc_pkg::ADDR_BLUE_TGT: next_s.rd_q = s.blue_tgt;
            vdtc_pkg::ADDR_RSV_FIXED: next_s.rd_q = s.rsv_fixed;
            vdtc_pkg::ADDR_AO_CTRL: next_s.rd_q = s.ao_ctrl;
            vdtc_pkg::ADDR_TEST: next_s.rd_q = s.test;
            default: next_s.rd_q = 8'h00;
        endcase

        // Pins pass three flops; a level counts once stages two and three agree.
        next_s.sync_pipe = {s.sync_pipe[1:0], line_sync_in};
        next_s.clamp_pipe = {s.clamp_pipe[1:0], clamp_pin};
        if (s.sync_pipe[2] == s.sync_pipe[1])
        begin
            next_s.sync_level = s.sync_pipe[2];
        end
        if (s.clamp_pipe[2] == s.clamp_pipe[1])
        begin
            next_s.clamp_level = s.clamp_pipe[2];
        end
        sync_fall = s.sync_level && (s.sync_pipe[2] == s.sync_pipe[1]) && !s.sync_pipe[2];

        // Internal clamp: wait placement periods after the trailing edge, then hold.
        if (sync_fall)
        begin
            next_s.delay_run = 1'b1;
            next_s.delay_cnt = s.clamp_start; // [R11]
        end
        else if (s.delay_run)
        begin
            next_s.delay_cnt = s.delay_cnt - 8'h01;
            if (s.delay_cnt <= 8'h01)
            begin
                next_s.delay_run = 1'b0;
                next_s.clamp_run = 1'b1; // [R11]
                next_s.clamp_cnt = s.clamp_len; // [R13]
            end
        end
        if (s.clamp_run && !(s.delay_run && s.delay_cnt <= 8'h01))
        begin
            next_s.clamp_cnt = s.clamp_cnt - 8'h01;
            if (s.clamp_cnt <= 8'h01)
            begin
                next_s.clamp_run = 1'b0; // [R13]
            end
        end
        next_s.clamp_q = clamp_external ? s.clamp_level : next_s.clamp_run; // [R14]

        // Output line sync: leading edge on feedback clock, width in pixel clocks.
        if (feedback_edge)
        begin
            next_s.hs_run = (s.sync_width != 8'h00);
            next_s.hs_cnt = s.sync_width; // [R15]
        end
        else if (s.hs_run)
        begin
            next_s.hs_cnt = s.hs_cnt - 8'h01;
            if (s.hs_cnt <= 8'h01)
            begin
                next_s.hs_run = 1'b0; // [R15]
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '0;
            s.div_upper <= vdtc_pkg::RST_DIV_UPPER; // [R4]
            s.div_lower <= vdtc_pkg::RST_DIV_LOWER; // [R4]
            s.divide <= vdtc_pkg::RST_DIVIDE; // [R4]
            s.clkgen <= vdtc_pkg::RST_CLKGEN; // [R6] [R8]
            s.phase <= vdtc_pkg::RST_PHASE; // [R10]
            s.clamp_start <= vdtc_pkg::RST_CLAMP_START;
            s.clamp_len <= vdtc_pkg::RST_CLAMP_LEN;
            s.sync_width <= vdtc_pkg::RST_SYNC_WIDTH;
            s.green_tgt <= vdtc_pkg::RST_TARGET; // [R17]
            s.blue_tgt <= vdtc_pkg::RST_TARGET; // [R17]
            s.rsv_fixed <= vdtc_pkg::RST_RSV_FIXED;
            s.ao_ctrl <= vdtc_pkg::RST_AO_CTRL; // [R19] [R21]
            s.test <= vdtc_pkg::RST_TEST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rd_data = s.rd_q;
    assign clamp_out = s.clamp_q;
    assign line_sync_out = s.hs_run;
    assign green_target = s.green_tgt;
    assign blue_target = s.blue_tgt;
    assign clock_cfg.band = s.clkgen[vdtc_pkg::BAND_HI:vdtc_pkg::BAND_LO]; // [R5]
    assign clock_cfg.pump = s.clkgen[vdtc_pkg::PUMP_HI:vdtc_pkg::PUMP_LO]; // [R7]
    assign clock_cfg.phase = s.phase[vdtc_pkg::PHASE_HI:vdtc_pkg::PHASE_LO]; // [R9]
    assign clock_cfg.divide = s.divide; // [R1]
    assign clock_cfg.ao_enable = s.ao_ctrl[vdtc_pkg::AO_EN_BIT]; // [R19]
    assign clock_cfg.ao_hold = s.ao_ctrl[vdtc_pkg::AO_HOLD_BIT]; // [R19]
    assign clock_cfg.ao_rate = s.ao_ctrl[vdtc_pkg::AO_RATE_HI:vdtc_pkg::AO_RATE_LO]; // [R21]

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_UPPER_ONLY: assert property (@(posedge sys_clk) disable iff (!nrst) // [R2]
        (req.wr && req.addr == vdtc_pkg::ADDR_DIV_UPPER) |=> $stable(clock_cfg.divide))
        else $error("Divide value changed on an upper-only write.");
    AST_LOWER_LOAD: assert property (@(posedge sys_clk) disable iff (!nrst) // [R1]
        (req.wr && req.addr == vdtc_pkg::ADDR_DIV_LOWER) |=>
        clock_cfg.divide == {s.div_upper, $past(req.wdata[7:4])})
        else $error("Divide value not loaded on a low-part write.");
    AST_REV_RO: assert property (@(posedge sys_clk) disable iff (!nrst) // [R16]
        (rd_addr == vdtc_pkg::ADDR_REVISION) |=> rd_data == vdtc_pkg::SILICON_REVISION)
        else $error("Revision register did not read its fixed value.");
    AST_EXT_CLAMP: assert property (@(posedge sys_clk) disable iff (!nrst) // [R14]
        clamp_external |=> clamp_out == $past(s.clamp_level))
        else $error("External clamp not followed.");
    sequence hs_start_seq;
        feedback_edge && s.sync_width == 8'h02;
    endsequence
    AST_HS_WIDTH: assert property (@(posedge sys_clk) disable iff (!nrst) // [R15]
        hs_start_seq ##1 !feedback_edge ##1 !feedback_edge |-> ##1 !line_sync_out)
        else $error("Line sync output wider than programmed.");
    AST_HS_START: assert property (@(posedge sys_clk) disable iff (!nrst) // [R15]
        (feedback_edge && s.sync_width != 8'h00) |=> line_sync_out)
        else $error("Line sync output did not start.");
    AST_HS_NONE: assert property (@(posedge sys_clk) disable iff (!nrst) // [R15]
        (feedback_edge && s.sync_width == 8'h00) |=> !line_sync_out)
        else $error("Line sync output started with zero width.");
    AST_CLAMP_START: assert property (@(posedge sys_clk) disable iff (!nrst) // [R11]
        (s.delay_run && s.delay_cnt == 8'h01 && !sync_fall) |=> s.clamp_run)
        else $error("Clamp did not start after placement count.");
    AST_CLAMP_END: assert property (@(posedge sys_clk) disable iff (!nrst) // [R13]
        (s.clamp_run && s.clamp_cnt == 8'h01 && !(s.delay_run && s.delay_cnt <= 8'h01))
        |=> !s.clamp_run)
        else $error("Clamp ran past its length.");
endmodule

// *** verif/vdtc_host_model.sv ***
// Purpose: Host model that writes and reads the timing control registers.
// Assumes: A write is a one-cycle wr pulse; read data follows one cycle later.
// Notes: The bench calls the tasks of this model by hierarchical name.
`timescale 1ns/1ps
module vdtc_host_model
(
    input wire logic sys_clk,
    output vdtc_pkg::reg_req_type req,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    initial req = '0;
    initial rd_addr = 8'h00;

    // Holds the request until the taking edge and lets one more edge pass.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge sys_clk);
        req.wr <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        rd_addr <= a;
        repeat (2) @(posedge sys_clk);
        #1;
        d = rd_data;
    endtask

    // The factory test register is never written by this host.
    task automatic keep_reserved();
        write_reg(vdtc_pkg::ADDR_RSV_FIXED, 8'h11);
    endtask
endmodule

// *** verif/tb_video_digitizer_timing_control.sv ***
// Purpose: Self-checking bench for the timing control register bank.
// Assumes: The host model drives the register port; pins are driven here.
// Notes: Expectations come from bench functions and shadow register copies.
`timescale 1ns/1ps
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin errors++; \
    $display("mismatch at %0t got %h expected %h", $time, act, exp); end end
module tb_video_digitizer_timing_control;
    logic sys_clk, nrst, line_sync_in, feedback_edge, clamp_external, clamp_pin;
    logic clamp_out, line_sync_out;
    logic [7:0] rd_addr, rd_data, green_target, blue_target, rd, cg, ph, ao, v, rb;
    logic [11:0] dv;
    vdtc_pkg::reg_req_type req;
    vdtc_pkg::clock_cfg_type clock_cfg;
    int errors, comparisons, cyc, sync_hi, clamp_hi, clamp_rise, fall, d1, d2;
    logic [7:0] ra [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e};
    logic [7:0] rv [13] = '{vdtc_pkg::SILICON_REVISION, 8'h69, 8'hd0, 8'h48, 8'h80,
        8'h01, 8'h01, 8'h01, 8'h04, 8'h04, 8'h11, 8'h26, 8'h00};

    vdtc_host_model i_host (.sys_clk(sys_clk), .req(req), .rd_addr(rd_addr), .rd_data(rd_data));
    video_digitizer_timing_control i_dut (.sys_clk(sys_clk), .nrst(nrst), .req(req),
        .rd_addr(rd_addr), .rd_data(rd_data), .line_sync_in(line_sync_in),
        .feedback_edge(feedback_edge), .clamp_external(clamp_external), .clamp_pin(clamp_pin),
        .clock_cfg(clock_cfg), .clamp_out(clamp_out), .line_sync_out(line_sync_out),
        .green_target(green_target), .blue_target(blue_target));

    function automatic vdtc_pkg::clock_cfg_type exp_cfg(input logic [11:0] d,
        input logic [7:0] c, input logic [7:0] p, input logic [7:0] a);
        exp_cfg = '{band: c[7:6], pump: c[5:3], phase: p[7:3], divide: d,
            ao_enable: a[7], ao_hold: a[6], ao_rate: a[1:0]};
    endfunction

    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always #2 sys_clk = ~sys_clk;

    // Cycle count moves on the falling edge so marks taken at rising edges never race it.
    always @(negedge sys_clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            errors++;
            print_verdict();
        end
    end

    always @(posedge sys_clk)
    begin
        if (line_sync_out === 1'b1)
            sync_hi++;
        if (clamp_out === 1'b1)
        begin
            if (clamp_hi == 0)
                clamp_rise = cyc;
            clamp_hi++;
        end
    end

    task automatic sync_pulse(input logic [7:0] w);
        i_host.write_reg(vdtc_pkg::ADDR_SYNC_WIDTH, w);
        @(negedge sys_clk);
        sync_hi = 0;
        @(posedge sys_clk);
        feedback_edge <= 1'b1;
        @(posedge sys_clk);
        feedback_edge <= 1'b0;
        repeat (int'(w) + 4) @(posedge sys_clk);
        `CHK(sync_hi, int'(w))
    endtask

    task automatic clamp_run(input logic [7:0] s, input logic [7:0] l, output int d);
        i_host.write_reg(vdtc_pkg::ADDR_CLAMP_START, s);
        i_host.write_reg(vdtc_pkg::ADDR_CLAMP_LEN, l);
        @(negedge sys_clk);
        clamp_hi = 0;
        clamp_rise = 0;
        @(posedge sys_clk);
        line_sync_in <= 1'b1;
        repeat (8) @(posedge sys_clk);
        line_sync_in <= 1'b0;
        fall = cyc;
        repeat (int'(s) + int'(l) + 20) @(posedge sys_clk);
        d = clamp_rise - fall;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        {line_sync_in, feedback_edge, clamp_external, clamp_pin} = 4'h0;
        {errors, comparisons, cyc, sync_hi, clamp_hi} = '0;
        void'($urandom(56));
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 13; i++)
        begin
            i_host.read_reg(ra[i], rd);
            `CHK(rd, rv[i])
        end
        dv = 12'd1693;
        {cg, ph, ao} = 24'h488026;
        `CHK(clock_cfg, exp_cfg(dv, cg, ph, ao))
        `CHK({green_target, blue_target}, 16'h0404)
        i_host.write_reg(vdtc_pkg::ADDR_REVISION, ~vdtc_pkg::SILICON_REVISION);
        i_host.write_reg(8'h10, 8'h5a);
        i_host.read_reg(vdtc_pkg::ADDR_REVISION, rd);
        `CHK(rd, vdtc_pkg::SILICON_REVISION)
        i_host.read_reg(8'h10, rd);
        `CHK(rd, 8'h00)
        for (int i = 0; i < 5; i++)
        begin
            v = 8'($urandom_range(255));
            rd = 8'($urandom_range(255));
            if (i == 3)
                {v, rd} = 16'h0020;
            if (i == 4)
                {v, rd} = 16'hfff0;
            if ({v, rd[7:4]} < 12'd2)
                v = 8'h01;
            i_host.write_reg(vdtc_pkg::ADDR_DIV_UPPER, v);
            `CHK(clock_cfg, exp_cfg(dv, cg, ph, ao))
            i_host.write_reg(vdtc_pkg::ADDR_DIV_LOWER, rd);
            dv = {v, rd[7:4]};
            `CHK(clock_cfg, exp_cfg(dv, cg, ph, ao))
            i_host.read_reg(vdtc_pkg::ADDR_DIV_UPPER, rb);
            `CHK(rb, v)
            i_host.read_reg(vdtc_pkg::ADDR_DIV_LOWER, rb);
            `CHK(rb, rd)
        end
        for (int i = 0; i < 8; i++)
        begin
            cg = {i[1:0], i[2:0], 3'($urandom_range(7))};
            ph = 8'($urandom_range(255));
            i_host.write_reg(vdtc_pkg::ADDR_CLKGEN, cg);
            i_host.write_reg(vdtc_pkg::ADDR_PHASE, ph);
            `CHK(clock_cfg, exp_cfg(dv, cg, ph, ao))
            i_host.read_reg(vdtc_pkg::ADDR_CLKGEN, rb);
            `CHK(rb, cg)
            i_host.read_reg(vdtc_pkg::ADDR_PHASE, rb);
            `CHK(rb, ph)
        end
        i_host.keep_reserved();
        i_host.read_reg(vdtc_pkg::ADDR_RSV_FIXED, rb);
        `CHK(rb, 8'h11)
        for (int i = 0; i < 4; i++)
        begin
            ao = {i[1:0], 4'h9, 2'($urandom_range(3))};
            v = 8'($urandom_range(255));
            i_host.write_reg(vdtc_pkg::ADDR_AO_CTRL, ao);
            i_host.write_reg(vdtc_pkg::ADDR_GREEN_TGT, v);
            i_host.write_reg(vdtc_pkg::ADDR_BLUE_TGT, ~v);
            `CHK(clock_cfg, exp_cfg(dv, cg, ph, ao))
            `CHK({green_target, blue_target}, {v, ~v})
            i_host.read_reg(vdtc_pkg::ADDR_AO_CTRL, rd);
            `CHK(rd, ao)
        end
        i_host.read_reg(vdtc_pkg::ADDR_GREEN_TGT, rb);
        `CHK(rb, v)
        i_host.read_reg(vdtc_pkg::ADDR_BLUE_TGT, rb);
        `CHK(rb, ~v)
        sync_pulse(8'h01);
        sync_pulse(8'h00);
        sync_pulse(8'h02);
        sync_pulse(8'($urandom_range(254, 2)));
        sync_pulse(8'hff);
        v = 8'($urandom_range(200, 1));
        rd = 8'($urandom_range(20, 1));
        clamp_run(v, rd, d1);
        `CHK(clamp_hi, int'(rd))
        i_host.read_reg(vdtc_pkg::ADDR_CLAMP_START, rb);
        `CHK(rb, v)
        i_host.read_reg(vdtc_pkg::ADDR_CLAMP_LEN, rb);
        `CHK(rb, rd)
        i_host.read_reg(vdtc_pkg::ADDR_SYNC_WIDTH, rb);
        `CHK(rb, 8'hff)
        clamp_run(v + 8'h07, rd, d2);
        `CHK(d2 - d1, 7)
        clamp_external <= 1'b1;
        clamp_run(v, rd, d1);
        `CHK(clamp_hi, 0)
        @(negedge sys_clk);
        clamp_hi = 0;
        @(posedge sys_clk);
        clamp_pin <= 1'b1;
        repeat (10) @(posedge sys_clk);
        clamp_pin <= 1'b0;
        repeat (10) @(posedge sys_clk);
        `CHK(clamp_hi, 10)
        // A reset in mid-run must bring the upper divide byte, clock fields, targets and outputs back to their power-up values.
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        i_host.read_reg(vdtc_pkg::ADDR_DIV_UPPER, rb);
        `CHK(rb, vdtc_pkg::RST_DIV_UPPER)
        {cg, ph, ao} = 24'h488026;
        `CHK(clock_cfg, exp_cfg(12'd1693, cg, ph, ao))
        `CHK({green_target, blue_target}, 16'h0404)
        `CHK({clamp_out, line_sync_out}, 2'b00)
        print_verdict();
    end
endmodule
